// file: bus_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module bus_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic jam,
  output logic sda_pull,
  output logic [7:0] rx_byte
);
  int nbit = 9;
  logic ack_q = 1'b0;
  logic jam_q = 1'b0;
  // Start on the wire restarts the bit count
  always @(negedge sda)
    if (scl)
      nbit = 0;
  // Data shifted in on the clock rise, first bit highest
  always @(posedge scl)
  begin
    if (nbit < 8)
      rx_byte = {rx_byte[6:0], sda};
    nbit = nbit + 1;
  end
  // Acknowledge and jamming change only while the clock is low
  always @(negedge scl)
  begin
    ack_q <= (nbit == 8);
    jam_q <= jam && (nbit < 8);
    if (nbit >= 9)
      nbit = 0;
  end
  assign sda_pull = ack_q | jam_q;
endmodule
`default_nettype wire

// file: i2c_bus_defs.svh
`ifndef I2C_BUS_DEFS_SVH
`define I2C_BUS_DEFS_SVH
// ==========================================
// Register indices (byte address is index times four)
`define IDX_PORT_DATA 16'hf220
`define IDX_PORT_DIR 16'hf221
`define IDX_DRIVE_LO 16'hf222
`define IDX_DRIVE_HI 16'hf223
`define IDX_FUNC_LO 16'hf224
`define IDX_FUNC_HI 16'hf225
`define IDX_RXD 16'hf2a0
`define IDX_TXD 16'hf2a1
`define IDX_CTL 16'hf2a2
`define IDX_MODE 16'hf2a4
`define IDX_STAT 16'hf2a5
`define IDX_ISTAT 16'hf2a6
`define IDX_IMASK 16'hf2a7
// ==========================================
// Field positions
`define MODE_EN 0
`define MODE_FAST 1
`define MODE_SYNC 4
`define CTL_GO 0
`define CTL_STOP 1
`define CTL_ACK 2
`define CTL_RX 3
`define IRQ_EV 0
`define IRQ_ER 1
`define PIN_SDA 0
`define PIN_SCL 1
`define REG_RST 8'h00
// ==========================================
// Phase lengths in high-speed clock periods
`define STD_LOW_BASE 8'h2c
`define STD_HIGH_BASE 8'h24
`define STD_STEP 8'h04
`define STD_HD_DAT 8'h08
`define FAST_HD_DAT 8'h04
`define FAST_LOW_TAB 32'h100e0e0c
`define FAST_HIGH_TAB 32'h0a0a0808
`endif

// file: i2c_bus_master.sv
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_bus_defs.svh"
module i2c_bus_master (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq,
  output logic bus_event_irq
);
  i2c_bus_pkg::core_state_t q, d;
  i2c_bus_pkg::phase_times_t t;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic acc;
  logic wr;
  logic [15:0] widx;
  logic wr_ctl;
  logic go;
  logic stop;
  logic en;
  logic sync_en;
  logic cnt_end;
  logic ev;
  logic err_set;
  logic start_seen;
  logic stop_seen;
  logic fn_sda;
  logic fn_scl;
  logic [7:0] sd_pt;
  logic [1:0] w1c;
  logic [1:0] iset;
  logic [7:0] stat_rd;

  // ==========================================
  // Pin synchronisers
  line_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Phase lengths from the mode register
  phase_timing u_timing (
    .fast(q.mode[`MODE_FAST]),
    .reduce(q.mode[3:2]),
    .times(t)
  );

  // ==========================================
  // Bus access decode
  always_comb
  begin
    acc = (avs_read | avs_write) & q.wreq;
    wr = acc & avs_write & avs_byteenable[0];
    widx = avs_address[17:2];
    wr_ctl = wr & (widx == `IDX_CTL);
    en = q.mode[`MODE_EN];
    sync_en = q.mode[`MODE_SYNC];
    go = wr_ctl & avs_writedata[`CTL_GO];
    stop = wr_ctl & avs_writedata[`CTL_STOP];
    w1c = (wr & (widx == `IDX_ISTAT)) ? avs_writedata[1:0] : 2'h0;
    fn_sda = ~q.port.mod1[`PIN_SDA] & q.port.mod0[`PIN_SDA];
    fn_scl = ~q.port.mod1[`PIN_SCL] & q.port.mod0[`PIN_SCL];
    sd_pt = 8'(t.low - t.hd_dat - 8'h01);
    cnt_end = (q.cnt == 8'h00);
    // Start and stop seen on the synchronised lines
    start_seen = scl_s & q.scl_seen & q.sda_seen & ~sda_s;
    stop_seen = scl_s & q.scl_seen & ~q.sda_seen & sda_s;
    stat_rd = {5'h00, q.arb_err, q.ack_rx, q.busy};
  end

  // ==========================================
  // Sequencer, registers and pins
  always_comb
  begin
    d = q;
    ev = 1'b0;
    err_set = 1'b0;
    d.scl_seen = scl_s;
    d.sda_seen = sda_s;
    d.lo_lvl = 1'b0;
    if (q.cnt != 8'h00)
      d.cnt = q.cnt - 8'h01;
    unique case (q.fsm)
      i2c_bus_pkg::ST_IDLE:
      begin
        d.scl_drv = 1'b0;
        d.sda_drv = 1'b0;
        if (go & en)
        begin
          d.fsm = i2c_bus_pkg::ST_START_SU;
          d.cnt = t.su_sta - 8'h01;
        end
      end
      i2c_bus_pkg::ST_START_SU:
        if (cnt_end)
        begin
          d.fsm = i2c_bus_pkg::ST_START_HD;
          d.sda_drv = 1'b1;
          d.cnt = t.hd_sta - 8'h01;
        end
      i2c_bus_pkg::ST_START_HD:
        if (cnt_end)
        begin
          // Address byte follows the start at once
          d.fsm = i2c_bus_pkg::ST_BIT_LOW;
          d.scl_drv = 1'b1;
          d.cnt = t.low - 8'h01;
          d.bitn = 4'h0;
          d.shift = q.txd;
          d.rx_mode = 1'b0;
        end
      i2c_bus_pkg::ST_BIT_LOW:
      begin
        if (q.cnt == sd_pt)
        begin
          // Data changes after the hold time
          if (q.bitn == 4'h8)
          begin
            d.bit_val = q.rx_mode ? q.ack_val : 1'b1;
            d.own = q.rx_mode;
          end
          else
          begin
            d.bit_val = q.rx_mode ? 1'b1 : q.shift[7];
            d.own = ~q.rx_mode;
          end
          d.sda_drv = ~d.bit_val & ~q.mute;
        end
        if (cnt_end)
        begin
          d.fsm = i2c_bus_pkg::ST_BIT_HIGH;
          d.scl_drv = 1'b0;
          d.cnt = t.high - 8'h01;
        end
      end
      i2c_bus_pkg::ST_BIT_HIGH:
      begin
        // Held low by a slower party: stretch the high phase
        if (sync_en & ~scl_s)
          d.cnt = q.cnt;
        else if (cnt_end)
        begin
          if (q.own & (sda_s != q.bit_val))
          begin
            err_set = 1'b1;
            if (sync_en)
            begin
              d.mute = 1'b1;
              d.sda_drv = 1'b0;
            end
          end
          d.scl_drv = 1'b1;
          if (q.bitn == 4'h8)
          begin
            d.ack_rx = sda_s;
            d.rxd = q.shift;
            d.mute = 1'b0;
            d.fsm = i2c_bus_pkg::ST_HOLD;
            ev = 1'b1;
          end
          else
          begin
            d.shift = {q.shift[6:0], sda_s};
            d.bitn = q.bitn + 4'h1;
            d.fsm = i2c_bus_pkg::ST_BIT_LOW;
            d.cnt = t.low - 8'h01;
          end
        end
      end
      i2c_bus_pkg::ST_HOLD:
      begin
        d.scl_drv = 1'b1;
        if (stop)
        begin
          d.fsm = i2c_bus_pkg::ST_STOP_LOW;
          d.sda_drv = 1'b1;
          d.cnt = t.low - 8'h01;
        end
        else if (go)
        begin
          d.fsm = i2c_bus_pkg::ST_BIT_LOW;
          d.cnt = t.low - 8'h01;
          d.bitn = 4'h0;
          d.shift = q.txd;
          d.rx_mode = avs_writedata[`CTL_RX];
          d.ack_val = avs_writedata[`CTL_ACK];
        end
      end
      i2c_bus_pkg::ST_STOP_LOW:
        if (cnt_end)
        begin
          d.fsm = i2c_bus_pkg::ST_STOP_SU;
          d.scl_drv = 1'b0;
          d.cnt = t.su_sto - 8'h01;
        end
      i2c_bus_pkg::ST_STOP_SU:
        if (sync_en & ~scl_s)
          d.cnt = q.cnt;
        else if (cnt_end)
        begin
          d.fsm = i2c_bus_pkg::ST_STOP_BUF;
          d.sda_drv = 1'b0;
          d.cnt = t.bus_free - 8'h01;
        end
      i2c_bus_pkg::ST_STOP_BUF:
        if (cnt_end)
        begin
          // Interrupt only once the stop and free time are over
          d.fsm = i2c_bus_pkg::ST_IDLE;
          ev = 1'b1;
        end
      default:
        d.fsm = i2c_bus_pkg::ST_IDLE;
    endcase

    // Busy tracking on the wire
    if (start_seen)
      d.busy = 1'b1;
    else if (stop_seen)
      d.busy = 1'b0;

    // Error flag: set wins over the write clear
    if (err_set)
      d.arb_err = 1'b1;
    else if (wr_ctl)
      d.arb_err = 1'b0;

    // Register writes
    if (wr)
    begin
      unique case (widx)
        `IDX_PORT_DATA: d.port.d = avs_writedata[7:0];
        `IDX_PORT_DIR: d.port.dir = avs_writedata[7:0];
        `IDX_DRIVE_LO: d.port.con0 = avs_writedata[7:0];
        `IDX_DRIVE_HI: d.port.con1 = avs_writedata[7:0];
        `IDX_FUNC_LO: d.port.mod0 = avs_writedata[7:0];
        `IDX_FUNC_HI: d.port.mod1 = avs_writedata[7:0];
        `IDX_TXD: d.txd = avs_writedata[7:0];
        `IDX_CTL: d.ctl = {4'h0, avs_writedata[3:2], 2'h0};
        `IDX_MODE: d.mode = {3'h0, avs_writedata[4:0]};
        `IDX_IMASK: d.irq_mask = avs_writedata[1:0];
        default: d.mode = d.mode;
      endcase
    end

    // Disabled: sequencer parked, flags held low
    if (~d.mode[`MODE_EN])
    begin
      d.fsm = i2c_bus_pkg::ST_IDLE;
      d.scl_drv = 1'b0;
      d.sda_drv = 1'b0;
      d.busy = 1'b0;
      d.arb_err = 1'b0;
      d.ack_rx = 1'b0;
      d.mute = 1'b0;
    end

    // Sticky interrupt status, set beats clear
    iset = {err_set, ev};
    d.irq_stat = (q.irq_stat & ~w1c) | iset;
    d.irq = |(d.irq_stat & d.irq_mask);
    d.ev_pulse = ev;

    // Pins: pull low or release only
    if (fn_sda)
      d.sda_oe_n = ~d.sda_drv;
    else
      d.sda_oe_n = q.port.dir[`PIN_SDA] | q.port.d[`PIN_SDA];
    if (fn_scl)
      d.scl_oe_n = ~d.scl_drv;
    else
      d.scl_oe_n = q.port.dir[`PIN_SCL] | q.port.d[`PIN_SCL];

    // Bus answer one cycle after the request
    d.wreq = ~acc;
    if (acc & avs_read)
    begin
      unique case (widx)
        `IDX_PORT_DATA: d.rdata = q.port.d;
        `IDX_PORT_DIR: d.rdata = q.port.dir;
        `IDX_DRIVE_LO: d.rdata = q.port.con0;
        `IDX_DRIVE_HI: d.rdata = q.port.con1;
        `IDX_FUNC_LO: d.rdata = q.port.mod0;
        `IDX_FUNC_HI: d.rdata = q.port.mod1;
        `IDX_RXD: d.rdata = q.rxd;
        `IDX_TXD: d.rdata = q.txd;
        `IDX_CTL: d.rdata = q.ctl;
        `IDX_MODE: d.rdata = q.mode;
        `IDX_STAT: d.rdata = stat_rd;
        `IDX_ISTAT: d.rdata = {6'h00, q.irq_stat};
        `IDX_IMASK: d.rdata = {6'h00, q.irq_mask};
        default: d.rdata = `REG_RST;
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.fsm <= i2c_bus_pkg::ST_IDLE;
      q.wreq <= 1'b1;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.scl_seen <= 1'b1;
      q.sda_seen <= 1'b1;
    end
    else
      q <= d;
  end

  // ==========================================
  // Outputs straight from the state register
  assign avs_readdata = {24'h000000, q.rdata};
  assign avs_waitrequest = q.wreq;
  assign scl_out = q.lo_lvl;
  assign sda_out = q.lo_lvl;
  assign scl_oe_n = q.scl_oe_n;
  assign sda_oe_n = q.sda_oe_n;
  assign irq = q.irq;
  assign bus_event_irq = q.ev_pulse;
endmodule
`default_nettype wire

// file: i2c_bus_master_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_master_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic irq,
  input wire logic bus_event_irq
);
  // ======
  // Helper: length of the running clock-low phase
  logic [15:0] low_cnt_q;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      low_cnt_q <= 16'h0000;
    else if (scl_oe_n)
      low_cnt_q <= 16'h0000;
    else if (low_cnt_q != 16'hffff)
      low_cnt_q <= low_cnt_q + 16'h0001;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ======
  // Pins and bus handshake
  chk_scl_open_drain: assert property (scl_out == 1'b0)
    else $error("clock line driven high");
  chk_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_wait_stands: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  // ======
  // Events and phases
  chk_irq_one_cycle: assert property (
    bus_event_irq |=> !bus_event_irq)
    else $error("event pulse too long");
  chk_stop_then_irq: assert property (
    $rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n)
    ##1 (scl_oe_n && sda_oe_n) [*8]
    |-> ##[1:60] bus_event_irq)
    else $error("no event after stop");
  chk_irq_not_early: assert property (
    bus_event_irq |-> (!scl_oe_n || sda_oe_n))
    else $error("event inside stop waveform");
  chk_low_phase_min: assert property (
    $rose(scl_oe_n) |-> low_cnt_q >= 16'h000c)
    else $error("clock low phase too short");
  cover property (bus_event_irq);
  cover property ($rose(sda_oe_n) && scl_oe_n);
  cover property (irq);
endmodule
bind i2c_bus_master i2c_bus_master_asserts chk (.clk_sys(clk_sys),
  .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .irq(irq), .bus_event_irq(bus_event_irq));
`default_nettype wire

// file: i2c_bus_pkg.sv
package i2c_bus_pkg;
  // ==========================================
  // Sequencer states
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_START_SU = 9'h002,
    ST_START_HD = 9'h004,
    ST_BIT_LOW = 9'h008,
    ST_BIT_HIGH = 9'h010,
    ST_HOLD = 9'h020,
    ST_STOP_LOW = 9'h040,
    ST_STOP_SU = 9'h080,
    ST_STOP_BUF = 9'h100
  } fsm_t;

  // Phase lengths for the selected speed
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] hd_dat;
    logic [7:0] hd_sta;
    logic [7:0] su_sta;
    logic [7:0] su_sto;
    logic [7:0] bus_free;
  } phase_times_t;

  // Port 4 register set
  typedef struct packed {
    logic [7:0] d;
    logic [7:0] dir;
    logic [7:0] con0;
    logic [7:0] con1;
    logic [7:0] mod0;
    logic [7:0] mod1;
  } port_regs_t;

  // Whole state of the bus master
  typedef struct packed {
    fsm_t fsm;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] rxd;
    logic [7:0] txd;
    logic [7:0] mode;
    logic [7:0] ctl;
    port_regs_t port;
    logic ack_rx;
    logic busy;
    logic arb_err;
    logic mute;
    logic rx_mode;
    logic ack_val;
    logic bit_val;
    logic own;
    logic scl_drv;
    logic sda_drv;
    logic scl_seen;
    logic sda_seen;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic ev_pulse;
    logic wreq;
    logic scl_oe_n;
    logic sda_oe_n;
    logic lo_lvl;
    logic [7:0] rdata;
  } core_state_t;
endpackage

// file: line_sync.sv
`timescale 1ns/10ps
`default_nettype none
module line_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } sync_t;
  sync_t q, d;

  // ==========================================
  // Two stages per line; only the second is read
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        d.s1[i] = async_in[i];
        d.s2[i] = q.s1[i];
      end
    end
  endgenerate

  // Stage registers, released lines idle high
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      q <= '1;
    else
      q <= d;
  end

  assign sync_out = q.s2;
endmodule
`default_nettype wire

// file: phase_timing.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_bus_defs.svh"
module phase_timing (
  input wire logic fast,
  input wire logic [1:0] reduce,
  output var i2c_bus_pkg::phase_times_t times
);
  logic [31:0] lo_tab;
  logic [31:0] hi_tab;
  logic [7:0] step;
  logic [7:0] f_low;
  logic [7:0] f_high;

  // ==========================================
  // Table lookup per reduction step in fast mode, base plus step in standard mode
  always_comb
  begin
    step = 8'(`STD_STEP * reduce);
    lo_tab = `FAST_LOW_TAB;
    hi_tab = `FAST_HIGH_TAB;
    f_low = lo_tab[8*reduce +: 8];
    f_high = hi_tab[8*reduce +: 8];
    if (fast)
    begin
      times.low = f_low;
      times.high = f_high;
      times.hd_dat = `FAST_HD_DAT;
      times.hd_sta = f_high;
      times.su_sta = f_low;
      times.su_sto = f_high;
      times.bus_free = f_low;
    end
    else
    begin
      times.low = 8'(`STD_LOW_BASE + step);
      times.high = 8'(`STD_HIGH_BASE + step);
      times.hd_dat = `STD_HD_DAT;
      times.hd_sta = 8'(`STD_HIGH_BASE + step);
      times.su_sta = 8'(`STD_LOW_BASE + step);
      times.su_sto = 8'(`STD_HIGH_BASE + step);
      times.bus_free = 8'(`STD_LOW_BASE + step);
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_bus_defs.svh"
module tb;
  logic clk_sys, rst, avs_read, avs_write, scl_in, sda_in, jam, msk;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic irq, bus_event_irq, sda_pull, run_lvl;
  logic [7:0] rx_byte, rd, tx;
  int num_errors, n_compared, seed, run_len, drv_hi, hi, lo;
  int hi_q[$];
  int lo_q[$];
  int fast_lo[4] = '{12, 14, 14, 16};
  int fast_hi[4] = '{8, 8, 10, 10};
  // Open-drain wires with pull-ups
  assign scl_in = scl_oe_n;
  assign sda_in = sda_oe_n & ~sda_pull;
  i2c_bus_master uut (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq),
    .bus_event_irq(bus_event_irq));
  bus_slave_model partner (.scl(scl_in), .sda(sda_in), .jam(jam),
    .sda_pull(sda_pull), .rx_byte(rx_byte));
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Clock phase lengths and driven-high-phase count
  always @(posedge clk_sys)
  begin
    if (scl_oe_n === 1'b1 && sda_oe_n === 1'b0 && lo_q.size() > 0)
      drv_hi++;
    if (scl_oe_n !== run_lvl)
    begin
      if (run_lvl)
        hi_q.push_back(run_len);
      else
        lo_q.push_back(run_len);
      run_lvl = scl_oe_n;
      run_len = 1;
    end
    else
      run_len++;
  end
  // ======
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [15:0] idx,
    input logic [7:0] v);
    int t;
    t = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, v};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && t < 50)
    begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 50)
      num_errors++;
    rd = avs_readdata[7:0];
    if (!wr)
      check(avs_readdata[31:8], 24'h000000);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_ev();
    int t;
    t = 0;
    while (bus_event_irq !== 1'b1 && t < 3000)
    begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 3000)
      num_errors++;
    // One more edge so the phase monitor has logged the last level
    @(posedge clk_sys);
  endtask
  task automatic send_addr(input logic [7:0] mode, input logic [7:0] v,
    input logic jm);
    xfer(1'b1, `IDX_MODE, mode);
    xfer(1'b1, `IDX_TXD, v);
    hi_q.delete();
    lo_q.delete();
    drv_hi = 0;
    jam = jm;
    xfer(1'b1, `IDX_CTL, 8'h01);
    wait_ev();
    jam = 1'b0;
  endtask
  task automatic stop_bus();
    xfer(1'b1, `IDX_CTL, 8'h02);
    wait_ev();
    check(scl_oe_n & sda_oe_n, 1'b1);
    xfer(1'b0, `IDX_STAT, 8'h00);
    check(rd[0], 1'b0);
    xfer(1'b1, `IDX_ISTAT, 8'h03);
    check(irq, 1'b0);
  endtask
  // ======
  // Main sequence
  initial
  begin
    seed = 32'h4759b531;
    rst = 1'b1;
    {avs_read, avs_write, jam} = 3'b000;
    avs_address = 18'h00000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    {num_errors, n_compared, run_len} = {32'd0, 32'd0, 32'd0};
    run_lvl = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(1'b0, `IDX_MODE, 8'h00);
    check(rd, 8'h00);
    xfer(1'b0, 16'h1234, 8'h00);
    check(rd, 8'h00);
    xfer(1'b1, 16'hf220, 8'($random(seed)) & 8'hfc);
    xfer(1'b1, 16'hf221, 8'($random(seed)) & 8'hfc);
    xfer(1'b1, 16'hf222, 8'($random(seed)) & 8'hfc);
    xfer(1'b1, 16'hf223, 8'($random(seed)) | 8'h03);
    xfer(1'b1, 16'hf224, 8'h03);
    xfer(1'b1, 16'hf225, 8'h00);
    xfer(1'b0, 16'hf224, 8'h00);
    check(rd, 8'h03);
    check({scl_oe_n, sda_oe_n}, 2'b11);
    // Every speed and reduction code
    for (int i = 0; i < 8; i++)
    begin
      msk = i[0];
      tx = 8'($random(seed));
      xfer(1'b1, `IDX_IMASK, {7'h00, msk});
      send_addr({4'h0, i[1:0], i[2], 1'b1}, tx, 1'b0);
      hi = i[2] ? fast_hi[i[1:0]] : 36 + 4 * i[1:0];
      lo = i[2] ? fast_lo[i[1:0]] : 44 + 4 * i[1:0];
      check(hi_q[1], hi);
      check(lo_q[1], lo);
      check(hi_q.size(), 10);
      check(rx_byte, tx);
      xfer(1'b0, `IDX_RXD, 8'h00);
      check(rd, tx);
      check(irq, msk);
      xfer(1'b0, `IDX_ISTAT, 8'h00);
      check(rd, 8'h01);
      xfer(1'b0, `IDX_STAT, 8'h00);
      check(rd, 8'h01);
      stop_bus();
    end
    // Lost arbitration without and with clock sync
    for (int s = 0; s < 2; s++)
    begin
      send_addr({3'b000, s[0], 4'h3}, 8'h80, 1'b1);
      check(drv_hi, s ? 0 : 56);
      xfer(1'b0, `IDX_STAT, 8'h00);
      check(rd, 8'h05);
      xfer(1'b1, `IDX_CTL, 8'h00);
      xfer(1'b0, `IDX_STAT, 8'h00);
      check(rd, 8'h01);
      stop_bus();
    end
    report_and_stop();
  end
  // Watchdog
  initial
  begin
    #(50 * 40000);
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
